/* ubid_params.svh */
// Constants for the serial port divisor, interrupt identification and DMA steering block.
// Assumes inclusion by bare name from every design file that needs register offsets or timing.
`ifndef UBID_PARAMS_SVH
`define UBID_PARAMS_SVH

// Register word offsets (byte addresses on the 32-bit register bus).
`define UBID_OFF_DATA        8'h00
`define UBID_OFF_IER         8'h04
`define UBID_OFF_IIR_FCR     8'h08
`define UBID_OFF_LCR         8'h0c
`define UBID_OFF_MCR         8'h10
`define UBID_OFF_LSR         8'h14
`define UBID_OFF_MSR         8'h18
`define UBID_OFF_SCR         8'h1c
`define UBID_OFF_CTRL        8'h20

// Field positions.
`define UBID_LCR_DIVISOR_LATCH_ACCESS    7
`define UBID_FCR_EN_BIT      0
`define UBID_FCR_RXCLR_BIT   1
`define UBID_FCR_TXCLR_BIT   2
`define UBID_CTRL_RXEN_BIT   2
`define UBID_CTRL_TXEN_BIT   6

// Interrupt identification codes.
`define UBID_ID_NONE         4'h1
`define UBID_ID_RLS          4'h6
`define UBID_ID_RDA          4'h4
`define UBID_ID_CTO          4'hc
`define UBID_ID_THRE         4'h2
`define UBID_ID_MSI          4'h0

// Receive trigger level codes and depths.
`define UBID_TRIG_1          5'h01
`define UBID_TRIG_8          5'h08
`define UBID_TRIG_4          5'h04
`define UBID_TRIG_14         5'h0e

// Reset values.
`define UBID_RST_CTRL        8'h00
`define UBID_RST_BYTE        8'h00

// Character time in baud ticks (16 ticks per bit, 10 bits) and timeout length.
`define UBID_CHAR_TICKS      8'ha0
`define UBID_TIMEOUT_CHARS   3'h4

`endif

/* ubid_pkg.sv */
// Types shared by the serial port divisor, interrupt identification and DMA block.
// Assumes the constants header sits beside it.
package ubid_pkg;

    // Receive status events from the receiver core.
    typedef struct packed {
        logic overrun;
        logic parity;
        logic framing;
        logic brk;
    } ubid_line_err_t;

    // Modem side input levels.
    typedef struct packed {
        logic dcd;
        logic ri;
        logic dsr;
        logic cts;
    } ubid_modem_t;

    // One DMA steering set: four channel request lines per direction.
    typedef struct packed {
        logic [3:0] rx_req;
        logic [3:0] tx_req;
    } ubid_dma_req_t;

    typedef enum logic [1:0] {
        UBID_BUS_IDLE,
        UBID_BUS_ANSWER
    } ubid_bus_state_t;

endpackage

/* ubid_baud_gen.sv */
// Baud tick generator: divides the system clock by a 16-bit divisor.
// Assumes the divisor is held stable between reloads; zero is not a legal divisor.
`timescale 1ns/1ps
module ubid_baud_gen
    import ubid_pkg::*;
(
    input  wire logic        clk_sys_in,
    input  wire logic        resetn_in,
    input  wire logic [15:0] divisor_in,
    input  wire logic        reload_in,
    output logic             tick_out
);

    logic [15:0] count;

    // Count down from the divisor; a write to either byte restarts the period at once. [RULE22]
    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            count    <= 16'h0000;
            tick_out <= 1'b0;
        end
        else if (reload_in)
        begin
            count    <= divisor_in;
            tick_out <= 1'b0;
        end
        else if (count <= 16'h0001)
        begin
            // A zero divisor also ticks every cycle here; the rate is meaningless anyway. [RULE4]
            count    <= divisor_in;
            tick_out <= 1'b1;
        end
        else
        begin
            count    <= count - 16'h0001;
            tick_out <= 1'b0;
        end
    end

endmodule

/* ubid_fifo_mem.sv */
// Small byte memory for the receive FIFO with registered read data.
// Assumes the caller never writes a full store or reads an empty one.
`timescale 1ns/1ps
module ubid_fifo_mem
    import ubid_pkg::*;
#(
    parameter int DEPTH_LOG2 = 4
)
(
    input  wire logic                  clk_sys_in,
    input  wire logic                  wr_en_in,
    input  wire logic [DEPTH_LOG2-1:0] wr_addr_in,
    input  wire logic [7:0]            wr_data_in,
    input  wire logic [DEPTH_LOG2-1:0] rd_addr_in,
    output logic      [7:0]            rd_data_out
);

    logic [7:0] mem [0:(1<<DEPTH_LOG2)-1];

    // Storage carries no reset; only the pointers decide what is valid.
    always_ff @(posedge clk_sys_in)
    begin
        if (wr_en_in)
        begin
            mem[wr_addr_in] <= wr_data_in;
        end
        rd_data_out <= mem[rd_addr_in];
    end

endmodule

/* ubid_core.sv */
// Serial port register front end: divisor latch, interrupt identification, DMA steering.
// Assumes a receiver core delivers bytes and errors, and a transmitter core drains bytes.
// Operation
// (RULE1) Divisor bytes visible only with access bit set
// (RULE2) Low byte bits 7:0, high byte 15:8
// (RULE3) Divisor bytes keep no reset value
// (RULE4) Software never programs an all-zero divisor
// (RULE5) Line status errors give code 0110, top
// (RULE6) Line status read clears that interrupt
// (RULE7) Data ready or trigger reached gives 0100
// (RULE8) Buffer read or fill drop clears it
// (RULE9) FIFO idle four characters gives 1100
// (RULE10) Receive buffer read clears character timeout
// (RULE11) Holding empty 0010, cleared by write/ID read
// (RULE12) Modem change gives 0000, status read clears
// (RULE13) Receive requests steered to channel when enabled
// (RULE14) Transmit requests steered to channel when enabled
// (RULE15) Receive requests are device-to-memory transfers
// (RULE16) Transmit requests are memory-to-device transfers
// (RULE17) Select fields choose among four channels
// (RULE18) Identification code in bits 3:0, shared address
// (RULE19) Trigger field: 00=1, 01=8, 11=14
// (RULE20) ID bits 7:6 show FIFO mode
// (RULE21) Code 0001 when idle; highest only reported
// (RULE22) Divisor divides clock, reloads on byte write
`timescale 1ns/1ps
`include "ubid_params.svh"
module ubid_core
    import ubid_pkg::*;
#(
    parameter int DEPTH_LOG2 = 4
)
(
    input  wire logic           clk_sys_in,
    input  wire logic           resetn_in,
    // Avalon-MM slave.
    input  wire logic [7:0]     avs_address_in,
    input  wire logic           avs_read_in,
    input  wire logic           avs_write_in,
    input  wire logic [3:0]     avs_byteenable_in,
    input  wire logic [31:0]    avs_writedata_in,
    output logic      [31:0]    avs_readdata_out,
    output logic                avs_waitrequest_out,
    // Receiver core side (same clock).
    input  wire logic           rx_valid_in,
    input  wire logic [7:0]     rx_data_in,
    input  wire ubid_line_err_t rx_err_in,
    // Transmitter core side (same clock).
    output logic                tx_valid_out,
    output logic      [7:0]     tx_data_out,
    input  wire logic           tx_ready_in,
    // Modem pins (asynchronous).
    input  wire ubid_modem_t    modem_in,
    output logic                baud_tick_out,
    output logic                irq_out,
    output ubid_dma_req_t       dma_req_out
);

    localparam int DEPTH = 1 << DEPTH_LOG2;

    // Bus state and decoded strobes.
    ubid_bus_state_t bus_state;
    logic [7:0]  lcr, ier, mcr, scr, ctrl, fcr_bits;
    logic [7:0]  div_low, div_high;
    logic        dlab, fifo_mode;
    logic        wr_go, rd_go;
    logic        wr_thr, wr_dll, wr_dlh, rd_rbr, rd_lsr, rd_msr, rd_iir;
    logic [31:0] next_rdata;

    assign dlab  = lcr[`UBID_LCR_DIVISOR_LATCH_ACCESS];
    assign wr_go = (bus_state == UBID_BUS_IDLE) && avs_write_in && avs_byteenable_in[0];
    assign rd_go = (bus_state == UBID_BUS_IDLE) && avs_read_in;

    // The shared data and interrupt-enable slots reach the divisor only with the latch bit set.
    assign wr_dll = wr_go && (avs_address_in == `UBID_OFF_DATA) && dlab;  // [RULE1]
    assign wr_dlh = wr_go && (avs_address_in == `UBID_OFF_IER) && dlab;   // [RULE1]
    assign wr_thr = wr_go && (avs_address_in == `UBID_OFF_DATA) && !dlab;
    assign rd_rbr = rd_go && (avs_address_in == `UBID_OFF_DATA) && !dlab;
    assign rd_lsr = rd_go && (avs_address_in == `UBID_OFF_LSR);
    assign rd_msr = rd_go && (avs_address_in == `UBID_OFF_MSR);
    assign rd_iir = rd_go && (avs_address_in == `UBID_OFF_IIR_FCR);

    // Every access waits one cycle so read data can come from a register.
    assign avs_waitrequest_out = (avs_read_in || avs_write_in) && (bus_state == UBID_BUS_IDLE);

    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
            bus_state <= UBID_BUS_IDLE;
        else if (bus_state == UBID_BUS_ANSWER)
            bus_state <= UBID_BUS_IDLE;
        else if (avs_read_in || avs_write_in)
            bus_state <= UBID_BUS_ANSWER;
    end

    // Divisor bytes have no reset branch at all; they are undefined until written. [RULE3]
    always_ff @(posedge clk_sys_in)
    begin
        if (wr_dll)
            div_low <= avs_writedata_in[7:0];   // [RULE2]
        if (wr_dlh)
            div_high <= avs_writedata_in[7:0];  // [RULE2]
    end

    ubid_baud_gen u_baud (
        .clk_sys_in (clk_sys_in),
        .resetn_in  (resetn_in),
        .divisor_in ({div_high, div_low}),      // [RULE2]
        .reload_in  (wr_dll || wr_dlh),         // [RULE22]
        .tick_out   (baud_tick_out)
    );

    // Plain control registers written from the bus.
    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            lcr      <= `UBID_RST_BYTE;
            ier      <= `UBID_RST_BYTE;
            mcr      <= `UBID_RST_BYTE;
            scr      <= `UBID_RST_BYTE;
            ctrl     <= `UBID_RST_CTRL;
            fcr_bits <= `UBID_RST_BYTE;
        end
        else if (wr_go)
        begin
            if (avs_address_in == `UBID_OFF_LCR)
                lcr <= avs_writedata_in[7:0];
            else if (avs_address_in == `UBID_OFF_IER && !dlab)
                ier <= avs_writedata_in[7:0];
            else if (avs_address_in == `UBID_OFF_MCR)
                mcr <= avs_writedata_in[7:0];
            else if (avs_address_in == `UBID_OFF_SCR)
                scr <= avs_writedata_in[7:0];
            else if (avs_address_in == `UBID_OFF_CTRL)
                ctrl <= avs_writedata_in[7:0];          // [RULE13] [RULE14]
            else if (avs_address_in == `UBID_OFF_IIR_FCR)
            begin
                // Bits 7:6 are taken only while the enable is written as one; a zero write clears every bit.
                if (avs_writedata_in[`UBID_FCR_EN_BIT])
                    fcr_bits <= {avs_writedata_in[7:6], 5'h00, 1'b1};
                else
                    fcr_bits <= `UBID_RST_BYTE;
            end
        end
    end

    assign fifo_mode = fcr_bits[`UBID_FCR_EN_BIT];

    // Receive FIFO: depth 1 in character mode, full depth in FIFO mode.
    logic [DEPTH_LOG2-1:0] wr_ptr, rd_ptr;
    logic [DEPTH_LOG2:0]   fill;
    logic [7:0]            rbr_q;
    logic                  rx_clr, push, pop, overrun_evt;
    logic [DEPTH_LOG2:0]   cap;

    assign rx_clr = wr_go && (avs_address_in == `UBID_OFF_IIR_FCR) &&
                    (avs_writedata_in[`UBID_FCR_RXCLR_BIT] ||
                     !avs_writedata_in[`UBID_FCR_EN_BIT] || !fifo_mode);
    assign cap    = fifo_mode ? (DEPTH_LOG2+1)'(DEPTH) : (DEPTH_LOG2+1)'(1);
    assign pop    = rd_rbr && (fill != '0);
    assign push   = rx_valid_in && ((fill < cap) || pop);
    assign overrun_evt = rx_valid_in && !push;

    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill   <= '0;
        end
        else if (rx_clr)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill   <= '0;
        end
        else
        begin
            if (push)
                wr_ptr <= wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= rd_ptr + 1'b1;
            if (push && !pop)
                fill <= fill + 1'b1;
            else if (pop && !push)
                fill <= fill - 1'b1;
        end
    end

    ubid_fifo_mem #(.DEPTH_LOG2(DEPTH_LOG2)) u_mem (
        .clk_sys_in  (clk_sys_in),
        .wr_en_in    (push),
        .wr_addr_in  (wr_ptr),
        .wr_data_in  (rx_data_in),
        .rd_addr_in  (pop ? rd_ptr + 1'b1 : rd_ptr),
        .rd_data_out (rbr_q)
    );

    // Line status sticky bits; a new error wins over the clearing read. [RULE6]
    logic [3:0] lsr_err;
    logic [3:0] err_evt;
    assign err_evt = {rx_valid_in && rx_err_in.brk, rx_valid_in && rx_err_in.framing,
                      rx_valid_in && rx_err_in.parity,
                      overrun_evt || (rx_valid_in && rx_err_in.overrun)};

    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
            lsr_err <= 4'h0;
        else
            lsr_err <= err_evt | (rd_lsr ? 4'h0 : lsr_err);  // [RULE6]
    end

    // Transmit holding register and its empty interrupt.
    logic thr_full, thre_pend;

    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            thr_full    <= 1'b0;
            tx_data_out <= 8'h00;
        end
        else if (wr_thr)
        begin
            thr_full    <= 1'b1;
            tx_data_out <= avs_writedata_in[7:0];
        end
        else if (tx_ready_in)
            thr_full <= 1'b0;
    end
    assign tx_valid_out = thr_full;

    // Modem pins pass two flops; deltas are sticky until the status read.
    ubid_modem_t modem_s1, modem_s2, modem_s3;
    logic [3:0]  msr_delta;

    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            modem_s1 <= '0;
            modem_s2 <= '0;
            modem_s3 <= '0;
        end
        else
        begin
            modem_s1 <= modem_in;
            modem_s2 <= modem_s1;
            modem_s3 <= modem_s2;
        end
    end

    // Bit order dcd, trailing ri, dsr, cts; change wins over the read. [RULE12]
    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
            msr_delta <= 4'h0;
        else
            msr_delta <= {modem_s2.dcd ^ modem_s3.dcd, modem_s3.ri & ~modem_s2.ri,
                          modem_s2.dsr ^ modem_s3.dsr, modem_s2.cts ^ modem_s3.cts} |
                         (rd_msr ? 4'h0 : msr_delta);
    end

    // Trigger depth from the two-bit threshold field. [RULE19]
    logic [4:0] rx_fifo_threshold;
    always_comb
    begin
        case (fcr_bits[7:6])
            2'b00:   rx_fifo_threshold = `UBID_TRIG_1;
            2'b01:   rx_fifo_threshold = `UBID_TRIG_8;
            2'b10:   rx_fifo_threshold = `UBID_TRIG_4;
            default: rx_fifo_threshold = `UBID_TRIG_14;
        endcase
    end

    // Data available follows the fill level, so a read or a drop removes it. [RULE7] [RULE8]
    logic rda_cond;
    assign rda_cond = fifo_mode ? (fill >= (DEPTH_LOG2+1)'(rx_fifo_threshold))
                                : (fill != '0);

    // Character timeout counts baud ticks while the FIFO is untouched. [RULE9]
    logic [7:0] tick_cnt;
    logic [2:0] char_cnt;
    logic       cto_pend;

    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            tick_cnt <= 8'h00;
            char_cnt <= 3'h0;
            cto_pend <= 1'b0;
        end
        else if (!fifo_mode || fill == '0 || push || pop || rx_clr)
        begin
            tick_cnt <= 8'h00;
            char_cnt <= 3'h0;
            cto_pend <= 1'b0;                                  // [RULE10]
        end
        else if (baud_tick_out && !cto_pend)
        begin
            if (tick_cnt == `UBID_CHAR_TICKS - 8'h01)
            begin
                tick_cnt <= 8'h00;
                char_cnt <= char_cnt + 3'h1;
                if (char_cnt == `UBID_TIMEOUT_CHARS - 3'h1)
                    cto_pend <= 1'b1;                          // [RULE9]
            end
            else
                tick_cnt <= tick_cnt + 8'h01;
        end
    end

    // Holding-empty event on the emptying edge; cleared by a write or the reporting ID read.
    logic thr_full_q, thre_reported;
    logic [3:0] pending_irq_code;

    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            thr_full_q <= 1'b0;
            thre_pend  <= 1'b1;
        end
        else
        begin
            thr_full_q <= thr_full;
            if (thr_full_q && !thr_full)
                thre_pend <= 1'b1;                             // [RULE11]
            else if (wr_thr || (rd_iir && thre_reported))
                thre_pend <= 1'b0;                             // [RULE11]
        end
    end

    // Priority encoder: only the highest pending enabled source is shown. [RULE21]
    always_comb
    begin
        thre_reported = 1'b0;
        if (ier[2] && (lsr_err != 4'h0))
            pending_irq_code = `UBID_ID_RLS;                   // [RULE5]
        else if (ier[0] && rda_cond)
            pending_irq_code = `UBID_ID_RDA;                   // [RULE7]
        else if (ier[0] && cto_pend)
            pending_irq_code = `UBID_ID_CTO;                   // [RULE9]
        else if (ier[1] && thre_pend)
        begin
            pending_irq_code = `UBID_ID_THRE;                  // [RULE11]
            thre_reported    = 1'b1;
        end
        else if (ier[3] && (msr_delta != 4'h0))
            pending_irq_code = `UBID_ID_MSI;                   // [RULE12]
        else
            pending_irq_code = `UBID_ID_NONE;                  // [RULE21]
    end

    assign irq_out = !pending_irq_code[0];

    // DMA steering: one-hot channel per direction, gated by each enable. [RULE15] [RULE16]
    genvar ch;
    generate
        for (ch = 0; ch < 4; ch++)
        begin : g_dma
            assign dma_req_out.rx_req[ch] = ctrl[`UBID_CTRL_RXEN_BIT] && (ctrl[1:0] == 2'(ch)) &&
                                            (fill != '0);                       // [RULE13] [RULE17]
            assign dma_req_out.tx_req[ch] = ctrl[`UBID_CTRL_TXEN_BIT] && (ctrl[5:4] == 2'(ch)) &&
                                            !thr_full;                          // [RULE14] [RULE17]
        end
    endgenerate

    // Read mux, registered into the answer cycle; unmapped offsets read zero.
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        if (avs_address_in == `UBID_OFF_DATA)
            next_rdata[7:0] = dlab ? div_low : rbr_q;          // [RULE1]
        else if (avs_address_in == `UBID_OFF_IER)
            next_rdata[7:0] = dlab ? div_high : ier;           // [RULE1]
        else if (avs_address_in == `UBID_OFF_IIR_FCR)
            next_rdata[7:0] = {fifo_mode, fifo_mode, 2'b00, pending_irq_code}; // [RULE18] [RULE20]
        else if (avs_address_in == `UBID_OFF_LCR)
            next_rdata[7:0] = lcr;
        else if (avs_address_in == `UBID_OFF_MCR)
            next_rdata[7:0] = mcr;
        else if (avs_address_in == `UBID_OFF_LSR)
            next_rdata[7:0] = {1'b0, !thr_full, !thr_full, lsr_err[3], lsr_err[2],
                               lsr_err[1], lsr_err[0], fill != '0};
        else if (avs_address_in == `UBID_OFF_MSR)
            next_rdata[7:0] = {modem_s2.dcd, modem_s2.ri, modem_s2.dsr, modem_s2.cts, msr_delta};
        else if (avs_address_in == `UBID_OFF_SCR)
            next_rdata[7:0] = scr;
        else if (avs_address_in == `UBID_OFF_CTRL)
            next_rdata[7:0] = ctrl;
    end

    always_ff @(posedge clk_sys_in or negedge resetn_in)
    begin
        if (!resetn_in)
            avs_readdata_out <= 32'h0000_0000;
        else if (rd_go)
            avs_readdata_out <= next_rdata;
    end

endmodule

/* ubid_core_checker.sv */
// Checker for the serial port front end: bus timing, identification codes, DMA lines.
// Assumes it is bound to ubid_core and sees only that module's ports.
`timescale 1ns/1ps
module ubid_core_checker
    import ubid_pkg::*;
(
    input  wire logic          clk_sys_in,
    input  wire logic          resetn_in,
    input  wire logic [7:0]    avs_address_in,
    input  wire logic          avs_read_in,
    input  wire logic          avs_write_in,
    input  wire logic [31:0]   avs_readdata_out,
    input  wire logic          avs_waitrequest_out,
    input  wire logic          tx_valid_out,
    input  wire logic [7:0]    tx_data_out,
    input  wire logic          tx_ready_in,
    input  wire logic          irq_out,
    input  wire ubid_dma_req_t dma_req_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!resetn_in);

    // A request is new, then answered; identification reads are a kind of answer.
    sequence s_req_new;
        (avs_read_in || avs_write_in) && !$past(avs_read_in || avs_write_in);
    endsequence
    sequence s_rd_done;
        avs_read_in && !avs_waitrequest_out;
    endsequence
    sequence s_id_done;
        s_rd_done ##0 (avs_address_in == 8'h08);
    endsequence

    a_wait_first: assert property (s_req_new |-> avs_waitrequest_out)
        else $error("waitrequest low in first request cycle");
    a_wait_once: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
        |=> !avs_waitrequest_out) else $error("more than one wait cycle");
    a_read_upper: assert property (s_rd_done |-> avs_readdata_out[31:8] == 24'h0)
        else $error("reserved read bits not zero");
    a_id_legal: assert property (s_id_done |-> avs_readdata_out[5:4] == 2'h0 &&
        avs_readdata_out[3:0] inside {4'h1, 4'h6, 4'h4, 4'hc, 4'h2, 4'h0})
        else $error("illegal identification code");
    a_id_none: assert property (s_id_done ##0 avs_readdata_out[3:0] == 4'h1
        |-> !$past(irq_out)) else $error("irq high while nothing reported");
    a_dma_single: assert property ($onehot0(dma_req_out.rx_req) &&
        $onehot0(dma_req_out.tx_req)) else $error("request on two channels");
    a_tx_hold: assert property (tx_valid_out && !tx_ready_in |=>
        tx_valid_out && $stable(tx_data_out)) else $error("transmit byte dropped");
    a_read_stands: assert property (!avs_read_in |=> $stable(avs_readdata_out))
        else $error("read data moved without a read");
endmodule

bind ubid_core ubid_core_checker u_chk (.clk_sys_in, .resetn_in, .avs_address_in,
    .avs_read_in, .avs_write_in, .avs_readdata_out, .avs_waitrequest_out, .tx_valid_out,
    .tx_data_out, .tx_ready_in, .irq_out, .dma_req_out);

/* ubid_far_model.sv */
// Far side model: receiver core, transmitter drain and modem pins.
// Assumes the bench calls its tasks right after a rising clock edge.
`timescale 1ns/1ps
module ubid_far_model
    import ubid_pkg::*;
(
    input  wire logic      clk_sys_in,
    input  wire logic      tx_valid_in,
    input  wire logic [7:0] tx_data_in,
    output logic           rx_valid_out,
    output logic [7:0]     rx_data_out,
    output ubid_line_err_t rx_err_out,
    output ubid_modem_t    modem_out,
    output logic           tx_ready_out
);
    logic [7:0] tx_seen = 8'h00;

    // Ready only every other cycle, so a held byte must wait for it.
    always @(posedge clk_sys_in)
    begin
        tx_ready_out <= !tx_ready_out;
        if (tx_valid_in && tx_ready_out)
            tx_seen <= tx_data_in;
    end

    // One character; afterwards the lines show the inverse, not a held value.
    task automatic send(input logic [7:0] b, input ubid_line_err_t e);
        rx_valid_out <= 1'b1;
        rx_data_out <= b;
        rx_err_out <= e;
        @(posedge clk_sys_in);
        rx_valid_out <= 1'b0;
        rx_data_out <= ~b;
        rx_err_out <= ~e;
        repeat (3) @(posedge clk_sys_in);
    endtask

    initial
    begin
        rx_valid_out = 1'b0;
        rx_data_out = 8'h00;
        rx_err_out = '0;
        modem_out = '0;
        tx_ready_out = 1'b0;
    end
endmodule

/* uart_baud_irq_dma_hookup_test.sv */
// Self-checking bench for the serial port front end with the far side model.
// Assumes the design, the checker and the far side model are compiled first.
`timescale 1ns/1ps
module uart_baud_irq_dma_hookup_test
    import ubid_pkg::*;
();
    logic clk_sys_in = 1'b0, resetn_in = 1'b0, avs_read_in = 1'b0, avs_write_in = 1'b0;
    logic [7:0] avs_address_in = 8'h00;
    logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, rdata;
    logic avs_waitrequest_out, tx_valid_out, tx_ready_in, rx_valid_in, baud_tick_out, irq_out;
    logic [7:0] tx_data_out, rx_data_in;
    ubid_line_err_t rx_err_in;
    ubid_modem_t modem_in;
    ubid_dma_req_t dma_req_out;
    int failures = 0, cmp_count = 0;
    time t0;

    ubid_core u_dut (.clk_sys_in, .resetn_in, .avs_address_in, .avs_read_in, .avs_write_in,
        .avs_byteenable_in(4'hf), .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out,
        .rx_valid_in, .rx_data_in, .rx_err_in, .tx_valid_out, .tx_data_out, .tx_ready_in,
        .modem_in, .baud_tick_out, .irq_out, .dma_req_out);
    ubid_far_model u_far (.clk_sys_in, .tx_valid_in(tx_valid_out), .tx_data_in(tx_data_out),
        .rx_valid_out(rx_valid_in), .rx_data_out(rx_data_in), .rx_err_out(rx_err_in),
        .modem_out(modem_in), .tx_ready_out(tx_ready_in));

    // Half period of the 200 MHz clock.
    always #2.5 clk_sys_in = ~clk_sys_in;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One bus cycle; the request is held until waitrequest is seen low at an edge.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        avs_address_in <= a;
        avs_writedata_in <= d;
        avs_read_in <= !w;
        avs_write_in <= w;
        do @(posedge clk_sys_in); while (avs_waitrequest_out !== 1'b0);
        rdata = avs_readdata_out;
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rdata, exp);
    endtask

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial
    begin
        repeat (10) @(posedge clk_sys_in);
        resetn_in <= 1'b1;
        bus(1'b1, 8'h0c, 32'h83);
        bus(1'b1, 8'h04, 32'ha5);
        rd(8'h04, 32'ha5);
        bus(1'b1, 8'h04, 32'h00);
        bus(1'b1, 8'h00, 32'h103);
        rd(8'h00, 32'h03);
        @(posedge baud_tick_out);
        t0 = $time;
        @(posedge baud_tick_out);
        chk(32'(($time - t0) / 5), 32'd3);
        bus(1'b1, 8'h0c, 32'h03);
        bus(1'b1, 8'h04, 32'h0f);
        rd(8'h04, 32'h0f);
        rd(8'h08, 32'h02);
        rd(8'h08, 32'h01);
        u_far.send(8'h5a, 4'h0);
        rd(8'h08, 32'h04);
        chk(32'(irq_out), 32'h1);
        rd(8'h00, 32'h5a);
        rd(8'h08, 32'h01);
        chk(32'(irq_out), 32'h0);
        u_far.send(8'h33, 4'h4);
        rd(8'h08, 32'h06);
        rd(8'h14, 32'h65);
        rd(8'h08, 32'h04);
        rd(8'h00, 32'h33);
        u_far.modem_out <= 4'h1;
        repeat (4) @(posedge clk_sys_in);
        rd(8'h08, 32'h00);
        rd(8'h18, 32'h11);
        rd(8'h08, 32'h01);
        bus(1'b1, 8'h00, 32'hc3);
        repeat (6) @(posedge clk_sys_in);
        chk(32'(u_far.tx_seen), 32'hc3);
        rd(8'h08, 32'h02);
        for (int i = 0; i < 4; i++)
        begin
            bus(1'b1, 8'h20, 32'(8'h44 | (i << 4) | i));
            chk(32'(dma_req_out), {28'h0, 4'h1 << i});
        end
        u_far.send(8'h21, 4'h0);
        chk(32'(dma_req_out), 32'h88);
        bus(1'b1, 8'h20, 32'h33);
        chk(32'(dma_req_out), 32'h00);
        rd(8'h00, 32'h21);
        bus(1'b1, 8'h08, 32'h01);
        u_far.send(8'h41, 4'h0);
        rd(8'h08, 32'hc4);
        rd(8'h00, 32'h41);
        bus(1'b1, 8'h08, 32'hc1);
        u_far.send(8'h77, 4'h0);
        repeat (1500) @(posedge clk_sys_in);
        rd(8'h08, 32'hc1);
        repeat (1100) @(posedge clk_sys_in);
        rd(8'h08, 32'hcc);
        rd(8'h00, 32'h77);
        rd(8'h08, 32'hc1);
        end_of_test();
    end

    // The run needs some 2800 cycles; this cuts a hang off well beyond that.
    initial
    begin
        #200000;
        failures++;
        end_of_test();
    end
endmodule
